// *** hdl/adc_ctl_pkg.sv ***
package adc_ctl_pkg;
  // register address and power-on value
  localparam logic [7:0] CONV_CTRL_ADDR  = 8'hD8;
  localparam logic [7:0] CONV_CTRL_RESET = 8'h00;
  // bit positions inside the register
  localparam int         DONE_POS        = 7;
  localparam int         DMA_POS         = 6;
  localparam int         CONT_POS        = 5;
  localparam int         SINGLE_POS      = 4;
  localparam int         CHAN_MSB        = 3;
  // channel codes
  localparam logic [3:0] CHAN_EXT_LAST   = 4'h7;
  localparam logic [3:0] CHAN_TEMP       = 4'h8;
  localparam logic [3:0] CHAN_DAC0       = 4'h9;
  localparam logic [3:0] CHAN_DAC1       = 4'hA;
  localparam logic [3:0] CHAN_GND        = 4'hB;
  localparam logic [3:0] CHAN_REF        = 4'hC;
  localparam logic [3:0] CHAN_DMA_STOP   = 4'hF;
  // temperature channel least acquisition time
  localparam int         TEMP_ACQ_NS     = 1000;
  localparam int         CLK_PERIOD_NS   = 8;
  localparam int         TEMP_ACQ_CYC    = (TEMP_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // special function register access from the core
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_wr;
    logic [2:0] bit_sel;
    logic       bit_val;
  } sfr_req_t;

  // request to the converter core
  typedef struct packed {
    logic       start;
    logic [3:0] chan;
  } conv_req_t;
endpackage : adc_ctl_pkg

// *** hdl/adc_conversion_control.sv ***
// Operation
// RULE_01 - done flag sets when a single conversion or a dma capture finishes
// RULE_02 - done flag clears on interrupt vectoring, otherwise software clears it
// RULE_03 - writing dma enable starts the prepared dma capture
// RULE_04 - address latch strobe is held off while dma enable is set
// RULE_05 - dma enable clears itself when the capture ends
// RULE_06 - continuous bit restarts a conversion as each one completes
// RULE_07 - single bit gives exactly one conversion, then clears itself
// RULE_08 - outside dma each conversion uses the channel select field
// RULE_09 - in dma the channel comes from the stored memory identifier
// RULE_10 - channel codes: 0-7 ext, 8 temp, 9/10 dacs, 11 gnd, 12 ref, 15 stop
// RULE_11 - temperature channel needs at least one microsecond acquisition
// RULE_12 - dac channels only used while the dac output buffer is on (not checked: no buffer input, codes 9/10 always convert)
// RULE_13 - the stop code in memory ends a dma capture
// RULE_14 - channel code fills the top four bits of the result high byte
module adc_conversion_control
  import adc_ctl_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire adc_ctl_pkg::sfr_req_t  sfr_req,
  output logic [7:0]                  sfr_rdata,
  input  wire logic                   irq_vector_ack,
  input  wire logic                   conv_busy,
  input  wire logic                   conv_end,
  input  wire logic [11:0]            conv_result,
  input  wire logic                   dma_chan_valid,
  input  wire logic [3:0]             dma_chan_id,
  output adc_ctl_pkg::conv_req_t      conv_req,
  output logic [7:0]                  result_high_byte,
  output logic [7:0]                  result_low_byte,
  output logic                        conv_done_flag,
  output logic                        dma_active,
  output logic                        ale_enable,
  output logic                        chan_reserved,
  output logic                        temp_acq_min
);
  import adc_ctl_pkg::*;

  typedef enum logic [1:0] {IDLE, CONVERT, DMA_RUN} ctl_state_t;

  ctl_state_t state;
  ctl_state_t next_state;
  logic       dma_bit;
  logic       cont_bit;
  logic       single_bit;
  logic [3:0] chan_sel;
  logic       next_done;
  logic       next_dma;
  logic       next_cont;
  logic       next_single;
  logic [3:0] next_chan;
  logic [3:0] cur_chan;
  logic [3:0] next_cur_chan;
  logic       start_q;
  logic       next_start;
  logic [7:0] next_rh;
  logic [7:0] next_rl;
  logic [7:0] reg_wval;
  logic       reg_hit;

  // channel code that names a defined source or the dma stop code
  function automatic logic chan_valid(input logic [3:0] c);
    chan_valid = (c <= CHAN_REF) || (c == CHAN_DMA_STOP);
  endfunction : chan_valid

  // full or bit write value presented to the register
  always_comb
  begin
    reg_wval = {conv_done_flag, dma_bit, cont_bit, single_bit, chan_sel};
    reg_hit  = (sfr_req.wr || sfr_req.bit_wr) && (sfr_req.addr == CONV_CTRL_ADDR);
    if (sfr_req.wr)
    begin
      reg_wval = sfr_req.wdata;
    end
    else if (sfr_req.bit_wr)
    begin
      reg_wval[sfr_req.bit_sel] = sfr_req.bit_val;
    end
  end

  // register and sequencer next values
  always_comb
  begin
    next_state    = state;
    next_done     = conv_done_flag;
    next_dma      = dma_bit;
    next_cont     = cont_bit;
    next_single   = single_bit;
    next_chan     = chan_sel;
    next_cur_chan = cur_chan;
    next_start    = 1'b0;
    next_rh       = result_high_byte;
    next_rl       = result_low_byte;
    // RULE_02 software side of the clear
    if (reg_hit)
    begin
      next_done   = reg_wval[DONE_POS];
      next_dma    = reg_wval[DMA_POS];
      next_cont   = reg_wval[CONT_POS];
      next_single = reg_wval[SINGLE_POS];
      next_chan   = reg_wval[CHAN_MSB:0];
    end
    // RULE_02 cleared on vectoring
    if (irq_vector_ack)
    begin
      next_done = 1'b0;
    end
    case (state)
      IDLE:
      begin
        // RULE_03 dma start
        if (dma_bit)
        begin
          next_state = DMA_RUN;
        end
        // RULE_06 RULE_07 RULE_08 software start
        else if ((single_bit || cont_bit) && !conv_busy)
        begin
          next_start    = 1'b1;
          next_cur_chan = chan_sel;
          next_state    = CONVERT;
        end
      end
      CONVERT:
      begin
        if (conv_end)
        begin
          // RULE_14 tag result with channel
          next_rh    = {cur_chan, conv_result[11:8]};
          next_rl    = conv_result[7:0];
          next_state = IDLE;
          if (single_bit)
          begin
            // RULE_07 self clear, RULE_01 flag set
            next_single = 1'b0;
            next_done   = 1'b1;
          end
        end
      end
      DMA_RUN:
      begin
        if (conv_end)
        begin
          next_rh = {cur_chan, conv_result[11:8]};
          next_rl = conv_result[7:0];
        end
        // RULE_09 RULE_13 channel from memory, stop code ends capture
        if (dma_chan_valid && !conv_busy && !start_q)
        begin
          if (dma_chan_id == CHAN_DMA_STOP)
          begin
            // RULE_05 RULE_01 self clear and flag
            next_dma   = 1'b0;
            next_done  = 1'b1;
            next_state = IDLE;
          end
          else
          begin
            next_start    = 1'b1;
            next_cur_chan = dma_chan_id;
          end
        end
        else if (!dma_bit)
        begin
          next_state = IDLE;
        end
      end
      default:
      begin
        next_state = IDLE;
      end
    endcase
  end

  // registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state            <= IDLE;
      conv_done_flag   <= CONV_CTRL_RESET[DONE_POS];
      dma_bit          <= CONV_CTRL_RESET[DMA_POS];
      cont_bit         <= CONV_CTRL_RESET[CONT_POS];
      single_bit       <= CONV_CTRL_RESET[SINGLE_POS];
      chan_sel         <= CONV_CTRL_RESET[CHAN_MSB:0];
      cur_chan         <= 4'h0;
      start_q          <= 1'b0;
      result_high_byte <= 8'h00;
      result_low_byte  <= 8'h00;
    end
    else
    begin
      state            <= next_state;
      conv_done_flag   <= next_done;
      dma_bit          <= next_dma;
      cont_bit         <= next_cont;
      single_bit       <= next_single;
      chan_sel         <= next_chan;
      cur_chan         <= next_cur_chan;
      start_q          <= next_start;
      result_high_byte <= next_rh;
      result_low_byte  <= next_rl;
    end
  end

  // outputs
  assign sfr_rdata     = (sfr_req.addr == CONV_CTRL_ADDR) ?
                         {conv_done_flag, dma_bit, cont_bit, single_bit, chan_sel} : 8'h00;
  assign conv_req.start = start_q;
  assign conv_req.chan  = cur_chan;
  assign dma_active     = (state == DMA_RUN);
  // RULE_04 strobe held off during dma
  assign ale_enable     = !dma_bit && (state != DMA_RUN);
  // RULE_10 decode flags
  assign chan_reserved  = !chan_valid(chan_sel);
  // RULE_11 acquisition hint for the temperature channel
  assign temp_acq_min   = (cur_chan == CHAN_TEMP);

  // elaboration check: the acquisition count must cover at least one cycle
  localparam int ACQ_CHECK = TEMP_ACQ_CYC;
  if (ACQ_CHECK < 1)
  begin : g_acq_check
    $error("temperature acquisition count below one cycle");
  end

  sequence s_single_end;
    state == CONVERT && single_bit && conv_end;
  endsequence

  a_single_done: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_01
    s_single_end |=> conv_done_flag) else $error("done flag not set after single");
  a_single_clear: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_07
    (s_single_end and !reg_hit) |=> !single_bit) else $error("single bit not cleared");
  a_vector_clear: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_02
    irq_vector_ack && !(state == CONVERT && conv_end && single_bit) && !dma_active
    |=> !conv_done_flag) else $error("done flag kept after vectoring");
  a_dma_enter: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_03
    state == IDLE && dma_bit |=> dma_active) else $error("dma did not start");
  a_ale_off: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_04
    dma_bit |-> !ale_enable) else $error("strobe active during dma");
  a_dma_stop: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_13
    dma_active && dma_chan_valid && !conv_busy && !start_q && dma_chan_id == CHAN_DMA_STOP
    && !reg_hit |=> !dma_bit && conv_done_flag && !dma_active) else $error("stop ignored");
  a_chan_soft: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_08
    state == IDLE && !dma_bit && (single_bit || cont_bit) && !conv_busy
    |=> conv_req.start && conv_req.chan == $past(chan_sel)) else $error("wrong channel");
  a_chan_dma: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_09
    conv_req.start && dma_active |-> conv_req.chan == $past(dma_chan_id))
    else $error("dma channel not from memory");
  a_result_tag: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_14
    state == CONVERT && conv_end |=> result_high_byte[7:4] == $past(cur_chan))
    else $error("result not tagged");
  a_cont_restart: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_06
    state == CONVERT && conv_end && cont_bit && !single_bit && !reg_hit
    ##1 !conv_busy && !dma_bit |=> conv_req.start) else $error("no restart");
endmodule : adc_conversion_control

// *** tb/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_ctl_pkg::*;

  typedef struct packed {
    logic [3:0] code;
    logic       resv;
    logic       temp;
  } row_t;

  logic       mclk;
  logic       rst_n;
  sfr_req_t   sfr_req;
  logic [7:0] sfr_rdata;
  logic       irq_vector_ack;
  logic       conv_busy;
  logic       conv_end;
  logic [11:0] conv_result;
  logic       dma_chan_valid;
  logic [3:0] dma_chan_id;
  conv_req_t  conv_req;
  logic [7:0] result_high_byte;
  logic [7:0] result_low_byte;
  logic       conv_done_flag;
  logic       dma_active;
  logic       ale_enable;
  logic       chan_reserved;
  logic       temp_acq_min;
  int         error_cnt;
  int         samples_checked;
  row_t       rows [15];

  adc_conversion_control adc_conversion_control_inst (
    .mclk(mclk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .irq_vector_ack(irq_vector_ack), .conv_busy(conv_busy), .conv_end(conv_end),
    .conv_result(conv_result), .dma_chan_valid(dma_chan_valid),
    .dma_chan_id(dma_chan_id), .conv_req(conv_req), .result_high_byte(result_high_byte),
    .result_low_byte(result_low_byte), .conv_done_flag(conv_done_flag),
    .dma_active(dma_active), .ale_enable(ale_enable), .chan_reserved(chan_reserved),
    .temp_acq_min(temp_acq_min));

  // 125 MHz core clock
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task final_report;
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // inputs move 1 ns after the rising edge
  task tick;
    @(posedge mclk);
    #1;
  endtask : tick

  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req.wr = 1'b1;
    sfr_req.addr = a;
    sfr_req.wdata = d;
    tick();
    sfr_req.wr = 1'b0;
  endtask : wr

  // converter model: goes busy on the start pulse
  task wait_start;
    int n;
    n = 0;
    while (conv_req.start !== 1'b1)
    begin
      tick();
      n++;
      if (n > 20)
      begin
        error_cnt++;
        final_report();
      end
    end
    conv_busy = 1'b1;
  endtask : wait_start

  task conv(input logic [11:0] r);
    repeat (temp_acq_min ? TEMP_ACQ_CYC : 3) tick();
    conv_end = 1'b1;
    conv_result = r;
    tick();
    conv_end = 1'b0;
    conv_busy = 1'b0;
  endtask : conv

  initial
  begin
    error_cnt = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    sfr_req = '0;
    sfr_req.addr = CONV_CTRL_ADDR;
    {irq_vector_ack, conv_busy, conv_end, dma_chan_valid} = 4'h0;
    conv_result = 12'h000;
    dma_chan_id = 4'h0;
    for (int i = 0; i < 15; i++)
      rows[i] = '{code: 4'(i), resv: (i == 13 || i == 14), temp: (i == 8)};
    repeat (10) tick();
    rst_n = 1'b1;
    chk({sfr_rdata, 7'h00, ale_enable}, {CONV_CTRL_RESET, 8'h01});
    // channel codes 0 to 14 each through a single conversion
    // dac buffers assumed on
    foreach (rows[i])
    begin
      wr(CONV_CTRL_ADDR, 8'h10 | 8'(rows[i].code));
      chk(chan_reserved, rows[i].resv);
      wait_start();
      chk(conv_req.chan, rows[i].code);
      chk(temp_acq_min, rows[i].temp);
      conv(12'hA5C ^ 12'(i));
      chk({result_high_byte, result_low_byte}, {rows[i].code, 12'hA5C ^ 12'(i)});
      chk({conv_done_flag, sfr_rdata}, {1'b1, 8'h80 | 8'(rows[i].code)});
      irq_vector_ack = 1'b1;
      tick();
      irq_vector_ack = 1'b0;
      chk(conv_done_flag, 1'b0);
    end
    // continuous mode restarts until stopped
    wr(CONV_CTRL_ADDR, 8'h23);
    wait_start();
    conv(12'h111);
    wait_start();
    chk({conv_req.chan, conv_done_flag}, {4'h3, 1'b0});
    wr(CONV_CTRL_ADDR, 8'h00);
    conv(12'h222);
    repeat (6)
    begin
      tick();
      chk(conv_req.start, 1'b0);
    end
    // other address ignored and reads zero
    wr(8'hD9, 8'h10);
    chk(sfr_rdata, 8'h00);
    sfr_req.addr = CONV_CTRL_ADDR;
    repeat (4) tick();
    chk({conv_req.start, sfr_rdata}, 9'h000);
    // bit write of the single bit
    sfr_req.bit_wr = 1'b1;
    sfr_req.bit_sel = 3'(SINGLE_POS);
    sfr_req.bit_val = 1'b1;
    tick();
    sfr_req.bit_wr = 1'b0;
    wait_start();
    conv(12'h333);
    chk(sfr_rdata, 8'h80);
    // dma capture: id 2 then the stop code
    wr(CONV_CTRL_ADDR, 8'h45);
    chk(ale_enable, 1'b0);
    dma_chan_valid = 1'b1;
    dma_chan_id = 4'h2;
    wait_start();
    dma_chan_valid = 1'b0;
    chk({conv_req.chan, dma_active}, {4'h2, 1'b1});
    conv(12'h444);
    chk(result_high_byte, 8'h24);
    dma_chan_id = CHAN_DMA_STOP;
    dma_chan_valid = 1'b1;
    tick();
    dma_chan_valid = 1'b0;
    dma_chan_id = 4'h5;
    tick();
    chk({sfr_rdata[7:6], dma_active, ale_enable}, 4'b1001);
    // reset after the dma capture has ended clears the register
    rst_n = 1'b0;
    repeat (2) tick();
    rst_n = 1'b1;
    chk({sfr_rdata, conv_done_flag}, 9'h000);
    final_report();
  end
endmodule : tb_top
